// ===== hdl/hashed_table_walk.sv
// hashed page table search: walker, registers and interrupt
//
// How it works
// - smallest table is 2^10 entry groups of 64 bytes, 64 Kbytes.
// - primary hash: low 19 segment id bits XOR zero-extended page index.
// - secondary hash is the bitwise inverse of the primary hash.
// - no hit in the primary group starts the secondary group search.
// - no hit in the secondary group raises a page fault.
// - address bits 7-15: high hash bits AND index mask, OR origin.
// - address bits 16-25 are the low ten hash bits; 26-31 are zero.
// - at most eight entries per group are examined.
// - table base comes from the high bits of the origin field.
// - the index mask picks which high hash bits reach the address.
// - descriptor: origin bits 0-15, reserved 16-22, mask 23-31.
// - hit needs hash-select clear in primary, set in secondary.
// - table reads are physical and coherence-required.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module hashed_table_walk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic miss_req,
  input wire logic [23:0] miss_virtual_segment_id,
  input wire logic [15:0] miss_page_index,
  output logic walk_busy,
  output logic walk_done,
  output logic walk_hit,
  output logic walk_fault,
  output logic [31:0] walk_rpn,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_physical,
  output logic mem_coherent,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  output logic irq
);
  walk_if w ();

  walk_pkg::walk_state_type state;
  walk_pkg::walk_state_type next_state;
  logic [walk_pkg::VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id;
  logic [walk_pkg::VIRTUAL_SEGMENT_ID_W-1:0] next_virtual_segment_id;
  logic [walk_pkg::PIDX_W-1:0] pidx;
  logic [walk_pkg::PIDX_W-1:0] next_pidx;
  logic secondary;
  logic next_secondary;
  logic [walk_pkg::IDX_W-1:0] idx;
  logic [walk_pkg::IDX_W-1:0] next_idx;
  logic next_busy;
  logic next_done;
  logic next_hit;
  logic next_fault;
  logic [31:0] next_rpn;
  logic next_mem_req;
  logic [31:0] next_mem_addr;
  logic ev_fault;
  logic ev_found;

  logic [31:0] desc;
  logic [31:0] next_desc;
  logic [walk_pkg::EV_W-1:0] status;
  logic [walk_pkg::EV_W-1:0] next_status;
  logic [walk_pkg::EV_W-1:0] imask;
  logic [walk_pkg::EV_W-1:0] next_imask;
  logic [walk_pkg::EV_W-1:0] clr;
  logic [walk_pkg::EV_W-1:0] ev;
  logic [31:0] next_rdata;
  logic next_irq;

  group_hash u_hash (
    .w(w)
  );

  entry_match u_match (
    .w(w)
  );

  // feed the helpers from the latched miss and the descriptor
  // descriptor is read live: software must not rewrite it mid-walk
  always_comb begin
    w.virtual_segment_id = virtual_segment_id;
    w.page_index = pidx;
    w.secondary = secondary;
    w.origin = desc[walk_pkg::ORG_MSB:walk_pkg::ORG_LSB];
    w.index_mask = desc[walk_pkg::IMASK_MSB:walk_pkg::IMASK_LSB];
    w.entry_hi = mem_rdata[63:32];
  end

  // search sequencer
  always_comb begin
    next_state = state;
    next_virtual_segment_id = virtual_segment_id;
    next_pidx = pidx;
    next_secondary = secondary;
    next_idx = idx;
    next_done = 1'b0;
    next_hit = 1'b0;
    next_fault = 1'b0;
    next_rpn = walk_rpn;
    next_mem_req = 1'b0;
    next_mem_addr = mem_addr;
    ev_fault = 1'b0;
    ev_found = 1'b0;
    unique case (state)
      walk_pkg::ST_IDLE: begin
        // a miss while busy is not taken; the requester waits on busy
        if (miss_req) begin
          next_virtual_segment_id = miss_virtual_segment_id;
          next_pidx = miss_page_index;
          next_secondary = 1'b0;
          next_idx = '0;
          next_state = walk_pkg::ST_FETCH;
        end
      end
      walk_pkg::ST_FETCH: begin
        // entry address: group base plus eight bytes per entry index
        next_mem_req = 1'b1;
        next_mem_addr = w.group_addr
          | {23'h0, idx, 6'(0)} >> walk_pkg::ENTRY_OFS_W;
        next_state = walk_pkg::ST_WAIT;
      end
      walk_pkg::ST_WAIT: begin
        if (mem_ack) begin
          if (w.hit) begin
            // first match ends the search
            next_done = 1'b1;
            next_hit = 1'b1;
            next_rpn = mem_rdata[31:0];
            ev_found = 1'b1;
            next_state = walk_pkg::ST_IDLE;
          end else if (idx == walk_pkg::LAST_IDX) begin
            // group exhausted without a match
            if (secondary) begin
              next_done = 1'b1;
              next_fault = 1'b1;
              ev_fault = 1'b1;
              next_state = walk_pkg::ST_IDLE;
            end else begin
              // primary exhausted: retry with the inverted hash
              next_secondary = 1'b1;
              next_idx = '0;
              next_state = walk_pkg::ST_FETCH;
            end
          end else begin
            next_idx = idx + 3'h1;
            next_state = walk_pkg::ST_FETCH;
          end
        end
      end
      default: begin
        next_state = walk_pkg::ST_IDLE;
      end
    endcase
    // busy follows the next state, so it falls together with done
    next_busy = (next_state != walk_pkg::ST_IDLE);
  end

  // walk state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= walk_pkg::ST_IDLE;
      virtual_segment_id <= '0;
      pidx <= '0;
      secondary <= 1'b0;
      idx <= '0;
    end else begin
      state <= next_state;
      virtual_segment_id <= next_virtual_segment_id;
      pidx <= next_pidx;
      secondary <= next_secondary;
      idx <= next_idx;
    end
  end

  // results and memory request; table reads go out physical and coherent
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      walk_busy <= 1'b0;
      walk_done <= 1'b0;
      walk_hit <= 1'b0;
      walk_fault <= 1'b0;
      walk_rpn <= walk_pkg::RESULT_RESET;
      mem_req <= 1'b0;
      mem_addr <= walk_pkg::ADDR_RESET;
      mem_physical <= 1'b1;
      mem_coherent <= 1'b1;
    end else begin
      walk_busy <= next_busy;
      walk_done <= next_done;
      walk_hit <= next_hit;
      walk_fault <= next_fault;
      walk_rpn <= next_rpn;
      mem_req <= next_mem_req;
      mem_addr <= next_mem_addr;
      mem_physical <= 1'b1;
      mem_coherent <= 1'b1;
    end
  end

  // event pulses from the sequencer, one bit per status position
  always_comb begin
    ev = '0;
    ev[walk_pkg::EV_FAULT] = ev_fault;
    ev[walk_pkg::EV_FOUND] = ev_found;
  end

  // software writes: descriptor, mask, and one-to-clear status bits
  always_comb begin
    next_desc = desc;
    next_imask = imask;
    clr = '0;
    if (reg_wr) begin
      case (reg_addr)
        walk_pkg::ADDR_DESC: begin
          // reserved bits 16-22 hold zero
          next_desc = reg_wdata & walk_pkg::DESC_WMASK;
        end
        walk_pkg::ADDR_STATUS: begin
          clr = reg_wdata[walk_pkg::EV_W-1:0];
        end
        walk_pkg::ADDR_IMASK: begin
          next_imask = reg_wdata[walk_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      desc <= walk_pkg::DESC_RESET;
      imask <= walk_pkg::IMASK_RESET;
    end else begin
      desc <= next_desc;
      imask <= next_imask;
    end
  end

  // sticky status, one bit per event; a set in the clearing cycle wins
  for (genvar b = 0; b < walk_pkg::EV_W; b++) begin : g_status
    assign next_status[b] = (status[b] & ~clr[b]) | ev[b];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status <= walk_pkg::STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // level interrupt follows the unmasked status bits
  always_comb begin
    next_irq = |(next_status & next_imask);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // read data stand for one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        walk_pkg::ADDR_DESC: next_rdata = desc;
        walk_pkg::ADDR_STATUS: next_rdata = {30'h0, status};
        walk_pkg::ADDR_IMASK: next_rdata = {30'h0, imask};
        walk_pkg::ADDR_STATE: next_rdata = {26'h0, walk_busy, secondary,
          idx, 1'b0};
        walk_pkg::ADDR_RESULT: next_rdata = walk_rpn;
        walk_pkg::ADDR_LAST: next_rdata = mem_addr;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/walk_pkg.sv
// constants and types shared by the table walk address generator
package walk_pkg;
  // register byte offsets on the software port
  localparam logic [7:0] ADDR_DESC = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IMASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_LAST = 8'h14;
  // table descriptor layout, bit 0 of the big-endian view is bit 31 here
  localparam int ORG_MSB = 31;
  localparam int ORG_LSB = 16;
  localparam int IMASK_MSB = 8;
  localparam int IMASK_LSB = 0;
  localparam logic [31:0] DESC_RESET = 32'h0000_0000;
  localparam logic [31:0] DESC_WMASK = 32'hFFFF_01FF;
  // status and interrupt mask layout
  localparam int EV_W = 2;
  localparam int EV_FAULT = 0;
  localparam int EV_FOUND = 1;
  localparam logic [EV_W-1:0] STATUS_RESET = 2'h0;
  localparam logic [EV_W-1:0] IMASK_RESET = 2'h0;
  // hash and entry group geometry
  localparam int VIRTUAL_SEGMENT_ID_W = 24;
  localparam int PIDX_W = 16;
  localparam int HASH_W = 19;
  localparam int HASH_LO_W = 10;
  localparam int HASH_HI_W = HASH_W - HASH_LO_W;
  localparam int ORG_HI_W = 7;
  localparam int GROUP_OFS_W = 6;
  localparam int IDX_W = 3;
  localparam int ENTRY_OFS_W = 3;
  localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;
  localparam int API_W = 6;
  // smallest table: 2^10 groups of 64 bytes
  localparam int MIN_GROUPS_LOG2 = 10;
  localparam int GROUP_BYTES = 64;
  localparam int MIN_TABLE_BYTES = GROUP_BYTES << MIN_GROUPS_LOG2;
  // translation entry upper word layout
  localparam int ENT_VALID = 31;
  localparam int ENT_VIRTUAL_SEGMENT_ID_MSB = 30;
  localparam int ENT_VIRTUAL_SEGMENT_ID_LSB = 7;
  localparam int ENT_HSEL = 6;
  localparam int ENT_API_MSB = 5;
  localparam int ENT_API_LSB = 0;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_WAIT = 2'b10
  } walk_state_type;
endpackage

// ===== hdl/walk_if.sv
// signals shared by the walker, the hash unit and the entry matcher
`timescale 1ns/1ps
`default_nettype none
interface walk_if;
  localparam int ORG_W = walk_pkg::ORG_MSB - walk_pkg::ORG_LSB + 1;
  logic [walk_pkg::VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id;
  logic [walk_pkg::PIDX_W-1:0] page_index;
  logic secondary;
  logic [ORG_W-1:0] origin;
  logic [walk_pkg::HASH_HI_W-1:0] index_mask;
  logic [31:0] group_addr;
  logic [31:0] entry_hi;
  logic hit;
  modport walker (output virtual_segment_id, page_index, secondary, origin, index_mask,
    entry_hi, input group_addr, hit);
  modport hasher (input virtual_segment_id, page_index, secondary, origin, index_mask,
    output group_addr);
  modport matcher (input virtual_segment_id, page_index, secondary, entry_hi, output hit);
endinterface
`default_nettype wire

// ===== hdl/group_hash.sv
// primary/secondary hash and entry group address
`timescale 1ns/1ps
`default_nettype none
module group_hash (
  walk_if.hasher w
);
  logic [walk_pkg::HASH_W-1:0] primary;
  logic [walk_pkg::HASH_W-1:0] hash;
  logic [walk_pkg::HASH_HI_W-1:0] mid;
  always_comb begin
    primary = w.virtual_segment_id[walk_pkg::HASH_W-1:0]
      ^ {3'h0, w.page_index};
    hash = w.secondary ? ~primary : primary;
    mid = (hash[walk_pkg::HASH_W-1:walk_pkg::HASH_LO_W] & w.index_mask)
      | w.origin[walk_pkg::HASH_HI_W-1:0];
    w.group_addr = {
      w.origin[15:walk_pkg::HASH_HI_W],
      mid,
      hash[walk_pkg::HASH_LO_W-1:0],
      6'h00};
  end
endmodule
`default_nettype wire

// ===== hdl/entry_match.sv
// hit test on the upper word of one translation entry
`timescale 1ns/1ps
`default_nettype none
module entry_match (
  walk_if.matcher w
);
  always_comb begin
    w.hit = w.entry_hi[walk_pkg::ENT_VALID]
      && (w.entry_hi[walk_pkg::ENT_VIRTUAL_SEGMENT_ID_MSB:walk_pkg::ENT_VIRTUAL_SEGMENT_ID_LSB]
        == w.virtual_segment_id)
      && (w.entry_hi[walk_pkg::ENT_HSEL] == w.secondary)
      && (w.entry_hi[walk_pkg::ENT_API_MSB:walk_pkg::ENT_API_LSB]
        == w.page_index[walk_pkg::PIDX_W-1:walk_pkg::PIDX_W-6]);
  end
endmodule
`default_nettype wire

// ===== test/walk_monitor.sv
// concurrent checks on the table walk ports
`timescale 1ns/1ps
`default_nettype none
module walk_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic miss_req,
  input wire logic [23:0] miss_virtual_segment_id,
  input wire logic [15:0] miss_page_index,
  input wire logic walk_busy,
  input wire logic walk_done,
  input wire logic walk_fault,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_physical,
  input wire logic mem_coherent,
  input wire logic mem_ack
);
  logic [31:0] desc;
  logic [23:0] vs;
  logic [15:0] pi;
  logic [4:0] rd_cnt;
  logic [18:0] h;
  logic take;
  assign take = miss_req && !walk_busy;
  // reads 8..15 use the inverted hash
  assign h = (vs[18:0] ^ {3'h0, pi}) ^ {19{rd_cnt[3]}};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      desc <= 32'h0000_0000;
      vs <= 24'h000000;
      pi <= 16'h0000;
      rd_cnt <= 5'h00;
    end else begin
      if (reg_wr && reg_addr == walk_pkg::ADDR_DESC)
        desc <= reg_wdata;
      if (take) begin
        vs <= miss_virtual_segment_id;
        pi <= miss_page_index;
        rd_cnt <= 5'h00;
      end else if (mem_req)
        rd_cnt <= rd_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_attr; mem_physical && mem_coherent; endproperty
  a_attr: assert property (p_attr) else $error("read attributes");
  property p_start; take |=> walk_busy ##1 mem_req; endproperty
  a_start: assert property (p_start) else $error("first read late");
  property p_base;
    mem_req |-> mem_addr[31:25] == desc[31:25] && mem_addr[2:0] == 3'h0;
  endproperty
  a_base: assert property (p_base) else $error("base bits");
  property p_low;
    mem_req |-> mem_addr[15:6] == h[9:0] && mem_addr[5:3] == rd_cnt[2:0];
  endproperty
  a_low: assert property (p_low) else $error("hash bits");
  property p_mid;
    mem_req |-> mem_addr[24:16] == ((h[18:10] & desc[8:0]) | desc[24:16]);
  endproperty
  a_mid: assert property (p_mid) else $error("masked bits");
  property p_max; mem_req |-> rd_cnt < 5'h10 && !walk_done; endproperty
  a_max: assert property (p_max) else $error("too many reads");
  property p_fault;
    walk_fault |-> walk_done && rd_cnt == 5'h10 && $past(mem_ack);
  endproperty
  a_fault: assert property (p_fault) else $error("early fault");
  property p_done; walk_done |-> $past(mem_ack) && !walk_busy; endproperty
  a_done: assert property (p_done) else $error("done timing");
  property p_sec; mem_req && rd_cnt == 5'h08 |-> $past(mem_ack, 2); endproperty
  a_sec: assert property (p_sec) else $error("secondary start");
endmodule
bind hashed_table_walk walk_monitor i_walk_monitor (
  .mclk(mclk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .miss_req(miss_req),
  .miss_virtual_segment_id(miss_virtual_segment_id),
  .miss_page_index(miss_page_index),
  .walk_busy(walk_busy),
  .walk_done(walk_done),
  .walk_fault(walk_fault),
  .mem_req(mem_req),
  .mem_addr(mem_addr),
  .mem_physical(mem_physical),
  .mem_coherent(mem_coherent),
  .mem_ack(mem_ack)
);
`default_nettype wire

// ===== test/table_memory.sv
// behavioural main memory holding the page table entries
`timescale 1ns/1ps
`default_nettype none
module table_memory (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [63:0] mem_rdata
);
  logic [63:0] store [logic [31:0]];
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 64'h0;
    forever begin
      @(posedge mclk);
      if (!rst && mem_req === 1'b1) begin
        repeat ($urandom_range(3)) @(posedge mclk);
        mem_ack <= 1'b1;
        // empty slots read as invalid entries
        mem_rdata <= store.exists(mem_addr) ? store[mem_addr]
          : {1'b0, 31'h5A5A_5A5A, mem_addr};
        @(posedge mclk);
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the table walk address generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic miss_req = 1'b0;
  logic [23:0] miss_virtual_segment_id = 24'h000000;
  logic [15:0] miss_page_index = 16'h0000;
  logic [31:0] reg_rdata, walk_rpn, mem_addr;
  logic walk_busy, walk_done, walk_hit, walk_fault, mem_req, irq;
  logic mem_physical, mem_coherent, mem_ack;
  logic [63:0] mem_rdata;
  int failures = 0;
  int num_checks = 0;
  always #25 mclk = ~mclk;
  hashed_table_walk i_hashed_table_walk (
    .mclk(mclk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .miss_req(miss_req),
    .miss_virtual_segment_id(miss_virtual_segment_id),
    .miss_page_index(miss_page_index),
    .walk_busy(walk_busy),
    .walk_done(walk_done),
    .walk_hit(walk_hit),
    .walk_fault(walk_fault),
    .walk_rpn(walk_rpn),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_physical(mem_physical),
    .mem_coherent(mem_coherent),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .irq(irq)
  );
  table_memory i_table_memory (
    .mclk(mclk),
    .rst(rst),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );
  task automatic test_done();
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    `CHK(reg_rdata, e)
  endtask
  function automatic logic [31:0] grp(logic [31:0] d, logic [23:0] v,
      logic [15:0] p, logic s);
    logic [18:0] h;
    h = (v[18:0] ^ {3'h0, p}) ^ {19{s}};
    return {d[31:25], (h[18:10] & d[8:0]) | d[24:16], h[9:0], 6'h00};
  endfunction
  function automatic logic [31:0] ent(logic [23:0] v, logic [15:0] p,
      logic s);
    return {1'b1, v, s, p[15:10]};
  endfunction
  // mode 0 primary hit, 1 secondary hit, 2 fault, 3 hit in both groups
  task automatic walk(input int mode);
    logic [31:0] d, rpn;
    logic [8:0] m;
    logic [23:0] v;
    logic [15:0] p;
    logic [5:0] o;
    logic [1:0] msk, st;
    logic sec;
    logic [2:0] ix;
    logic [31:0] last;
    int n;
    m = 9'h1FF >> $urandom_range(9);
    d = ($urandom & 32'hFFFF_0000) | {23'h0, m};
    d[24:16] = d[24:16] & ~m;
    v = 24'($urandom);
    p = 16'($urandom);
    rpn = $urandom;
    o = {3'($urandom_range(7)), 3'h0};
    msk = 2'($urandom);
    st = (mode == 2) ? 2'b01 : 2'b10;
    i_table_memory.store.delete();
    reg_write(walk_pkg::ADDR_DESC, d);
    reg_write(walk_pkg::ADDR_IMASK, {30'h0, msk});
    i_table_memory.store[grp(d, v, p, 1'b0) + o] =
      {ent(v, p, 1'b1), ~rpn};
    i_table_memory.store[grp(d, v, p, 1'b1) + o] =
      {ent(v, p, 1'b0), ~rpn};
    if (mode != 2)
      i_table_memory.store[grp(d, v, p, mode == 1) + o] =
        {ent(v, p, mode == 1), rpn};
    if (mode == 3)
      i_table_memory.store[grp(d, v, p, 1'b1) + o] =
        {ent(v, p, 1'b1), ~rpn};
    @(posedge mclk);
    miss_req <= 1'b1;
    miss_virtual_segment_id <= v;
    miss_page_index <= p;
    @(posedge mclk);
    miss_req <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (walk_done !== 1'b1 && n < 400);
    if (walk_done !== 1'b1) begin
      failures++;
      test_done();
    end
    `CHK({walk_hit, walk_fault}, st)
    if (mode != 2) `CHK(walk_rpn, rpn)
    sec = (mode == 1 || mode == 2);
    ix = (mode == 2) ? 3'h7 : o[5:3];
    last = grp(d, v, p, sec) + {26'h0, ix, 3'h0};
    reg_check(walk_pkg::ADDR_STATE, {26'h0, 1'b0, sec, ix, 1'b0});
    reg_check(walk_pkg::ADDR_LAST, last);
    if (mode != 2) reg_check(walk_pkg::ADDR_RESULT, rpn);
    reg_check(walk_pkg::ADDR_IMASK, {30'h0, msk});
    repeat (3) @(negedge mclk);
    `CHK(irq, |(msk & st))
    reg_check(walk_pkg::ADDR_STATUS, {30'h0, st});
    reg_write(walk_pkg::ADDR_STATUS, 32'h0000_0003);
    reg_check(walk_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK(irq, 1'b0)
  endtask
  initial begin
    void'($urandom(32'h9473));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    reg_check(walk_pkg::ADDR_DESC, walk_pkg::DESC_RESET);
    reg_write(walk_pkg::ADDR_DESC, 32'hFFFF_FFFF);
    reg_check(walk_pkg::ADDR_DESC, walk_pkg::DESC_WMASK);
    reg_check(8'hFC, 32'h0000_0000);
    for (int k = 0; k < 24; k++)
      walk(k % 4);
    test_done();
  end
endmodule
`default_nettype wire
